// ==== core/ppi_top.sv ====
// palette pixel input and host bus stage with ahb-lite register access
// ==========================================================================
// Overview of operation
// - width pin selects 8 or 6 bit color
// - 6-bit: msb is bit 5, upper bits zero
// - blank low forces outputs to blanking level
// - blank low ignores pixel and overlay inputs
// - pixel, overlay, sync, blank latched on rise
// - one eight-bit two-way host data bus
// - inverted select pin ORed with enable bit
// - select pin low enables mode from bit 5
// - four overlay selects choose the color source
// - overlay source chosen ignores pixel index
// - lookup mode: index picks one of 256
// - direct mode 1 latches on both edges
// - register select latched on read fall
// - sync low switches off 40 IRE source
// - sync applies alongside other inputs
// - pedestal pin selects 0 or 7.5 IRE
// - write data on rise, select on fall
// - direct word: low byte first, high second
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module ppi_top
  import ppi_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pixel_clock_pin,
  input wire ppi_pkg::ppi_pix_pins_s pix_pins,
  input wire logic direct_color_select_n,
  input wire logic width_8bit_select,
  input wire logic pedestal_select,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic [2:0] host_register_select,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  output ppi_pkg::ppi_video_s video_out
);
  import ppi_pkg::*;

  localparam int SYNC_W = 1 + $bits(ppi_pix_pins_s) + 3 + 2 + 3 + 8 + 2;

  // ==========================================================================
  // pin synchronisers: three stages, values taken from stage 2, edges seen where stages 2 and 3 differ
  logic [SYNC_W-1:0] pin_bus;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync3_r;

  assign pin_bus = {pixel_clock_pin, pix_pins, direct_color_select_n, width_8bit_select,
                    pedestal_select, host_read_n, host_write_n, host_register_select,
                    host_data_bus_in, 2'b00};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
      sync3_r <= '1;
    end
    else
    begin
      sync1_r <= pin_bus;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // stage 2 view of every pin, aligned with the edge detection below
  logic pclk_s2;
  logic pclk_s3;
  ppi_pix_pins_s pix_s2;
  logic dcs_n_s2;
  logic width8_s2;
  logic pedestal_s2;
  logic rd_n_s2;
  logic rd_n_s3;
  logic wr_n_s2;
  logic wr_n_s3;
  logic [2:0] rs_s2;
  logic [7:0] data_s2;
  logic [1:0] pad_s2;

  assign {pclk_s2, pix_s2, dcs_n_s2, width8_s2, pedestal_s2, rd_n_s2, wr_n_s2, rs_s2,
          data_s2, pad_s2} = sync2_r;
  assign pclk_s3 = sync3_r[SYNC_W-1];
  assign rd_n_s3 = sync3_r[14];
  assign wr_n_s3 = sync3_r[13];

  logic pclk_rise;
  logic pclk_fall;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;

  assign pclk_rise = pclk_s2 && !pclk_s3;
  assign pclk_fall = !pclk_s2 && pclk_s3;
  assign rd_fall = !rd_n_s2 && rd_n_s3;
  assign rd_rise = rd_n_s2 && !rd_n_s3;
  assign wr_fall = !wr_n_s2 && wr_n_s3;
  assign wr_rise = wr_n_s2 && !wr_n_s3;

  // ==========================================================================
  // command register and mode decode
  logic [7:0] command_r;
  logic [7:0] color_data_r;
  logic [2:0] host_rs_r;
  ppi_mode_e mode;
  logic direct_enable;

  assign direct_enable = !dcs_n_s2 || command_r[PPI_CMD_DIRECT_EN_BIT];

  always_comb
  begin
    // bit 5 picks which direct mode
    if (!direct_enable)
      mode = PPI_MODE_LOOKUP;
    else if (command_r[PPI_CMD_MODE_SEL_BIT])
      mode = PPI_MODE_DIRECT_2;
    else
      mode = PPI_MODE_DIRECT_1;
  end

  function automatic logic is_color_rs(input logic [2:0] rs);
    is_color_rs = (rs == PPI_RS_COLOR_LUT) || (rs == PPI_RS_COLOR_OVL);
  endfunction

  // width pin sets color bits per cycle
  function automatic logic [7:0] color_mask(input logic wide);
    color_mask = wide ? 8'hff : PPI_COLOR_MASK_6BIT;
  endfunction

  // ==========================================================================
  // ahb-lite slave: zero wait state, registered read data
  logic addr_phase;
  logic wr_pending_r;
  logic [7:0] wr_addr_r;
  logic ahb_cmd_write;
  logic ahb_color_write;

  assign addr_phase = hsel && htrans[1] && hready;
  assign ahb_cmd_write = wr_pending_r && (wr_addr_r == PPI_ADDR_CTRL);
  assign ahb_color_write = wr_pending_r && (wr_addr_r == PPI_ADDR_COLOR);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pending_r <= addr_phase && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  logic [31:0] read_mux;

  always_comb
  begin
    read_mux = 32'h0000_0000;
    case (haddr[7:0])
      PPI_ADDR_CTRL: read_mux = {24'h00_0000, command_r};
      PPI_ADDR_STATUS:
      begin
        read_mux[PPI_ST_BLANK_BIT] = video_out.blank;
        read_mux[PPI_ST_SYNC_OFF_BIT] = video_out.sync_off;
        read_mux[PPI_ST_PEDESTAL_BIT] = video_out.pedestal_75;
        read_mux[PPI_ST_WIDTH8_BIT] = width8_s2;
        read_mux[PPI_ST_DIRECT_BIT] = direct_enable;
        read_mux[PPI_ST_MODE2_BIT] = (mode == PPI_MODE_DIRECT_2);
        read_mux[PPI_ST_LUT_SRC_BIT] = video_out.lut_source;
      end
      PPI_ADDR_PIXEL: read_mux = {20'h0_0000, video_out.overlay_select, video_out.lut_index};
      PPI_ADDR_DIRECT: read_mux = {15'h0000, video_out.direct_valid, video_out.direct_word};
      PPI_ADDR_COLOR: read_mux = {24'h00_0000, color_data_r & color_mask(width8_s2)};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
      hrdata <= read_mux;
  end

  // ==========================================================================
  // host strobe interface
  // select latched on falling read strobe
  // select latched on falling write strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      host_rs_r <= 3'h0;
    else if (rd_fall || wr_fall)
      host_rs_r <= rs_s2;
  end

  logic host_write_now;

  // data taken on the rising write strobe
  assign host_write_now = wr_rise;

  // a host write on the same cycle as a bus write wins; the pins are slower and rarer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      command_r <= PPI_CMD_RESET;
    else if (host_write_now && host_rs_r == PPI_RS_COMMAND)
      command_r <= data_s2;
    else if (ahb_cmd_write)
      command_r <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      color_data_r <= PPI_COLOR_RESET;
    // bits 6 and 7 dropped in 6-bit width
    else if (host_write_now && is_color_rs(host_rs_r))
      color_data_r <= data_s2 & color_mask(width8_s2);
    else if (ahb_color_write)
      color_data_r <= hwdata[7:0] & color_mask(width8_s2);
  end

  logic [7:0] host_read_value;

  always_comb
  begin
    host_read_value = 8'h00;
    // upper bits read zero in 6-bit width
    if (is_color_rs(rs_s2))
      host_read_value = color_data_r & color_mask(width8_s2);
    else if (rs_s2 == PPI_RS_COMMAND)
      host_read_value = command_r;
  end

  // drive only while the read strobe stays low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      host_data_bus_out <= 8'h00;
      host_data_bus_oe_n <= 1'b1;
    end
    else if (rd_fall)
    begin
      host_data_bus_out <= host_read_value;
      host_data_bus_oe_n <= 1'b0;
    end
    else if (rd_rise)
      host_data_bus_oe_n <= 1'b1;
  end

  // ==========================================================================
  // pixel capture
  // both edges in mode 1, rising otherwise
  logic pixel_edge;
  ppi_byte_e byte_phase_r;
  logic [7:0] low_byte_r;

  assign pixel_edge = pclk_rise || (pclk_fall && mode == PPI_MODE_DIRECT_1);

  // low byte first, high byte second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      byte_phase_r <= PPI_BYTE_LOW;
      low_byte_r <= 8'h00;
    end
    else if (mode == PPI_MODE_LOOKUP)
      byte_phase_r <= PPI_BYTE_LOW;
    else if (pixel_edge)
    begin
      case (byte_phase_r)
        PPI_BYTE_LOW:
        begin
          low_byte_r <= pix_s2.pixel_index_in;
          byte_phase_r <= PPI_BYTE_HIGH;
        end
        PPI_BYTE_HIGH: byte_phase_r <= PPI_BYTE_LOW;
        default: byte_phase_r <= PPI_BYTE_LOW;
      endcase
    end
  end

  // control inputs on every rising edge
  // rising edge captures controls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      video_out.blank <= 1'b1;
      video_out.sync_off <= 1'b0;
      video_out.pedestal_75 <= 1'b0;
    end
    else if (pclk_rise)
    begin
      video_out.blank <= !pix_s2.blank_n;
      // sync low drops the 40 IRE source
      // sync does not gate the other inputs
      video_out.sync_off <= !pix_s2.sync_n;
      // pedestal pin high means 7.5 IRE
      video_out.pedestal_75 <= pedestal_s2;
    end
  end

  // source selection and lookup index on rising edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      video_out.lut_source <= 1'b0;
      video_out.overlay_select <= 4'h0;
      video_out.lut_index <= 8'h00;
    end
    else if (pclk_rise)
    begin
      // blanked pixels ignore index and overlay
      if (!pix_s2.blank_n)
      begin
        video_out.lut_source <= 1'b0;
        video_out.overlay_select <= 4'h0;
        video_out.lut_index <= 8'h00;
      end
      else if (pix_s2.overlay_select != 4'h0)
      begin
        video_out.lut_source <= 1'b0;
        video_out.overlay_select <= pix_s2.overlay_select;
        video_out.lut_index <= 8'h00;
      end
      else
      begin
        // zero overlay uses the lookup entry in lookup mode only
        video_out.lut_source <= (mode == PPI_MODE_LOOKUP);
        video_out.overlay_select <= 4'h0;
        video_out.lut_index <= pix_s2.pixel_index_in;
      end
    end
  end

  // direct word completes on the second captured edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      video_out.direct_valid <= 1'b0;
      video_out.direct_word <= 16'h0000;
    end
    else if (mode == PPI_MODE_LOOKUP)
      video_out.direct_valid <= 1'b0;
    else if (pixel_edge && byte_phase_r == PPI_BYTE_HIGH)
    begin
      video_out.direct_valid <= pix_s2.blank_n;
      // a blanked word carries no pixel data
      video_out.direct_word <= pix_s2.blank_n ? {pix_s2.pixel_index_in, low_byte_r} : 16'h0000;
    end
  end

endmodule // ppi_top

// ==== core/ppi_pkg.sv ====
// package: constants, types and register map of the palette pixel and host input stage
package ppi_pkg;

  // ==========================================================================
  // register map (byte addresses on the ahb-lite bus)
  localparam logic [7:0] PPI_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PPI_ADDR_STATUS = 8'h04;
  localparam logic [7:0] PPI_ADDR_PIXEL = 8'h08;
  localparam logic [7:0] PPI_ADDR_DIRECT = 8'h0c;
  localparam logic [7:0] PPI_ADDR_COLOR = 8'h10;

  // ==========================================================================
  // command register fields and reset value
  localparam int PPI_CMD_DIRECT_EN_BIT = 7;
  localparam int PPI_CMD_MODE_SEL_BIT = 5;
  localparam logic [7:0] PPI_CMD_RESET = 8'h00;
  localparam logic [7:0] PPI_COLOR_RESET = 8'h00;
  localparam logic [7:0] PPI_COLOR_MASK_6BIT = 8'h3f;

  // ==========================================================================
  // host register select codes
  localparam logic [2:0] PPI_RS_COLOR_LUT = 3'h1;
  localparam logic [2:0] PPI_RS_COLOR_OVL = 3'h5;
  localparam logic [2:0] PPI_RS_COMMAND = 3'h6;

  // ==========================================================================
  // status register fields
  localparam int PPI_ST_BLANK_BIT = 0;
  localparam int PPI_ST_SYNC_OFF_BIT = 1;
  localparam int PPI_ST_PEDESTAL_BIT = 2;
  localparam int PPI_ST_WIDTH8_BIT = 3;
  localparam int PPI_ST_DIRECT_BIT = 4;
  localparam int PPI_ST_MODE2_BIT = 5;
  localparam int PPI_ST_LUT_SRC_BIT = 6;

  typedef enum logic [1:0] {
    PPI_MODE_LOOKUP,
    PPI_MODE_DIRECT_1,
    PPI_MODE_DIRECT_2
  } ppi_mode_e;

  typedef enum logic {
    PPI_BYTE_LOW,
    PPI_BYTE_HIGH
  } ppi_byte_e;

  // pixel-side pins as they arrive from the graphics controller
  typedef struct packed {
    logic [7:0] pixel_index_in;
    logic [3:0] overlay_select;
    logic sync_n;
    logic blank_n;
  } ppi_pix_pins_s;

  // latched per-pixel result handed to the converter stage
  typedef struct packed {
    logic blank;
    logic sync_off;
    logic pedestal_75;
    logic lut_source;
    logic [3:0] overlay_select;
    logic [7:0] lut_index;
    logic direct_valid;
    logic [15:0] direct_word;
  } ppi_video_s;

endpackage

// ==== verif/ppi_monitor.sv ====
// checker: port assertions of the palette pixel and host input stage
`timescale 1ns/1ps
module ppi_monitor
  import ppi_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pedestal_select,
  input wire logic width_8bit_select,
  input wire logic host_read_n,
  input wire logic [2:0] host_register_select,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe_n,
  input wire ppi_pkg::ppi_video_s video_out
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================================
  // host read steps
  sequence s_rd_held;
    $fell(host_read_n) ##1 !host_read_n [*5];
  endsequence

  sequence s_six_read;
    (!width_8bit_select && !host_data_bus_oe_n
      && host_register_select == PPI_RS_COLOR_LUT) [*4];
  endsequence

  // ==========================================================================
  // assertions
  chk_blank_clear:
    assert property (video_out.blank |-> !video_out.lut_source
      && video_out.lut_index == 8'h00 && video_out.overlay_select == 4'h0)
    else $error("blank pixel kept its inputs");
  chk_blank_level:
    assert property (video_out.blank |-> video_out.direct_word == 16'h0000)
    else $error("blank pixel kept direct color");
  chk_ovl_source:
    assert property (video_out.overlay_select != 4'h0 |-> !video_out.lut_source)
    else $error("overlay pixel took lookup color");
  chk_ready_okay:
    assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus stalled or errored");
  chk_idle_release:
    assert property (host_read_n [*8] |-> host_data_bus_oe_n)
    else $error("data bus driven with no read");
  chk_read_drive:
    assert property (s_rd_held |-> !host_data_bus_oe_n)
    else $error("data bus not driven in read");
  chk_six_bit:
    assert property (s_six_read |-> host_data_bus_out[7:6] == 2'b00)
    else $error("upper bits set in narrow read");
  chk_ped_follow:
    assert property ($changed(video_out.pedestal_75)
      |-> video_out.pedestal_75 == pedestal_select)
    else $error("pedestal differs from its pin");
endmodule // ppi_monitor

bind ppi_top ppi_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .pedestal_select(pedestal_select), .width_8bit_select(width_8bit_select),
  .host_read_n(host_read_n), .host_register_select(host_register_select),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_n(host_data_bus_oe_n),
  .video_out(video_out));

// ==== verif/ppi_gfx_model.sv ====
// graphics controller model: pixel clock and pixel pins
`timescale 1ns/1ps
module ppi_gfx_model
  import ppi_pkg::*;
(
  input wire logic hclk,
  output logic pixel_clock_pin,
  output ppi_pkg::ppi_pix_pins_s pix_pins
);
  initial
  begin
    pixel_clock_pin = 1'b0;
    pix_pins = '1;
  end

  // ==========================================================================
  // one pixel clock phase, pins settle well before the edge
  task automatic step(input ppi_pix_pins_s p, input logic lvl);
    if (p.blank_n)
      p.sync_n = 1'b1;
    @(posedge hclk);
    pix_pins <= p;
    repeat (4) @(posedge hclk);
    pixel_clock_pin <= lvl;
    repeat (4) @(posedge hclk);
  endtask

  task automatic pair(input ppi_pix_pins_s a, input ppi_pix_pins_s b, input logic dual);
    step(a, 1'b1);
    step(b, 1'b0);
    if (!dual)
    begin
      step(b, 1'b1);
      step(b, 1'b0);
    end
    // clock stands still, so the pins no longer carry a valid pixel
    pix_pins <= ~pix_pins;
  endtask
endmodule // ppi_gfx_model

// ==== verif/testbench.sv ====
// testbench: self-checking run of the palette pixel and host input stage
`timescale 1ns/1ps
module testbench;
  import ppi_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hrdy, hresp, pclk, dsel_n, w8, ped, rd_n, wr_n, oe_n;
  logic [31:0] haddr, hwdata, hrdata, rnd, rv;
  logic [1:0] htrans;
  logic [2:0] hsize, rs;
  logic [7:0] hdrv, bout, b;
  logic [15:0] m;
  wire logic [7:0] hbus;
  ppi_pix_pins_s pins;
  ppi_video_s vo;
  int n_errors = 0;
  int checks = 0;

  assign hbus = oe_n ? hdrv : bout;

  ppi_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .pixel_clock_pin(pclk), .pix_pins(pins),
    .direct_color_select_n(dsel_n), .width_8bit_select(w8), .pedestal_select(ped),
    .host_read_n(rd_n), .host_write_n(wr_n), .host_register_select(rs),
    .host_data_bus_in(hbus), .host_data_bus_out(bout), .host_data_bus_oe_n(oe_n),
    .video_out(vo));
  ppi_gfx_model u_gfx (.hclk(hclk), .pixel_clock_pin(pclk), .pix_pins(pins));

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // mode 2 only shows while direct color is enabled by pin or command bit
  // no pixel clock rise has happened yet, so the pedestal flag keeps its reset value
  function automatic logic [31:0] st_exp(input logic pin_n, input logic [7:0] c, input logic w);
    logic en;
    en = !pin_n | c[PPI_CMD_DIRECT_EN_BIT];
    return {26'h0, c[PPI_CMD_MODE_SEL_BIT] & en, en, w, 1'b0, 2'b0};
  endfunction

  // overlay pixels carry no index; blanked pixels carry neither
  function automatic logic [15:0] vid_exp(input logic [7:0] i, input logic [3:0] o,
      input logic s, input logic bl, input logic p);
    if (!bl)
      return {1'b1, !s, p, 13'h0};
    return {2'b00, p, o == 4'h0, o, o == 4'h0 ? i : 8'h00};
  endfunction

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    rv = hrdata;
  endtask

  // select is swapped after the fall: the one taken at the fall must hold
  task automatic hwr(input logic [2:0] s, input logic [7:0] d);
    @(posedge hclk);
    rs <= s;
    hdrv <= d;
    repeat (5) @(posedge hclk);
    wr_n <= 1'b0;
    repeat (5) @(posedge hclk);
    rs <= 3'h0;
    repeat (4) @(posedge hclk);
    wr_n <= 1'b1;
    repeat (6) @(posedge hclk);
    hdrv <= ~d;
  endtask

  task automatic hrd(input logic [7:0] exp);
    @(posedge hclk);
    rs <= PPI_RS_COLOR_LUT;
    repeat (5) @(posedge hclk);
    rd_n <= 1'b0;
    repeat (9) @(posedge hclk);
    check({24'h0, hbus}, {24'h0, exp});
    rs <= PPI_RS_COMMAND;
    repeat (4) @(posedge hclk);
    check({24'h0, hbus}, {24'h0, exp});
    rd_n <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, rs, hdrv} = '0;
    {dsel_n, w8, ped, rd_n, wr_n} = 5'h1f;
    hsize = 3'h2;
    rnd = 32'h99e326e8;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, PPI_ADDR_CTRL, 32'h0);
    check(rv, {24'h0, PPI_CMD_RESET});
    ahb(1'b1, 8'h40, 32'hffffffff);
    ahb(1'b0, 8'h40, 32'h0);
    check(rv, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      dsel_n <= k[0];
      w8 <= k[1];
      b = {k[2], 1'b0, k[1], 5'h0};
      ahb(1'b1, PPI_ADDR_CTRL, {24'h0, b});
      repeat (4) @(posedge hclk);
      ahb(1'b0, PPI_ADDR_STATUS, 32'h0);
      check(rv & 32'h3c, st_exp(k[0], b, k[1]));
    end
    $display("mode test done");
    dsel_n <= 1'b1;
    ahb(1'b1, PPI_ADDR_CTRL, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      b = {2'b11, rnd[5:0]};
      w8 <= k[0];
      hwr(k[1] ? PPI_RS_COLOR_OVL : PPI_RS_COLOR_LUT, b);
      ahb(1'b0, PPI_ADDR_COLOR, 32'h0);
      check(rv, {24'h0, k[0] ? b : b & PPI_COLOR_MASK_6BIT});
      hrd(k[0] ? b : b & PPI_COLOR_MASK_6BIT);
    end
    $display("host test done");
    ped <= 1'b0;
    for (int k = 0; k < 24; k++)
    begin
      rnd = lfsr(rnd);
      ped <= rnd[14];
      m = vid_exp(rnd[7:0], k[0] ? rnd[11:8] : 4'h0, rnd[13], k[1:0] != 2'd2, rnd[14]);
      u_gfx.pair({rnd[7:0], k[0] ? rnd[11:8] : 4'h0, rnd[13], k[1:0] != 2'd2},
        {rnd[7:0], k[0] ? rnd[11:8] : 4'h0, rnd[13], k[1:0] != 2'd2}, 1'b0);
      check({29'h0, vo[32:30]}, {29'h0, m[15:13]});
      check({19'h0, vo[29:17]}, {19'h0, m[12:0]});
    end
    $display("pixel test done");
    dsel_n <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      ahb(1'b1, PPI_ADDR_CTRL, k ? 32'h20 : 32'h0);
      repeat (4) @(posedge hclk);
      rnd = lfsr(rnd);
      u_gfx.pair({rnd[7:0], 4'h0, 2'b11}, {rnd[15:8], 4'h0, 2'b11}, k == 0);
      check({15'h0, vo[16:0]}, {15'h0, 1'b1, rnd[15:0]});
    end
    $display("direct test done");
    print_verdict;
  end

  initial
  begin
    #200000;
    n_errors++;
    print_verdict;
  end
endmodule // testbench
